// File: hw/ratemeter_defines.vh
// shared offsets, field positions, reset values and timing for the ratemeter
`ifndef RATEMETER_DEFINES_VH
`define RATEMETER_DEFINES_VH

// rate values are unsigned counts of 0.01 mR/h
`define RATE_W 24

// register byte offsets
`define CTRL_ADDR 8'h00
`define WARN_SP_ADDR 8'h04
`define HIGH_SP_ADDR 8'h08
`define RANGE_SEL_ADDR 8'h0C
// range g: underrange at slot*8 + g*8, overrange 4 bytes above it
`define RANGE_SP_SLOT 5'h02
`define STATUS_ADDR 8'h28
`define MEAN_ADDR 8'h2C

// control register fields
`define CTRL_MANUAL_BIT 0
`define CTRL_CHK_ALARM_BIT 1
`define CTRL_RESET 2'h1

// setpoint reset values
`define WARN_SP_RESET 24'h0000FA
`define HIGH_SP_RESET 24'h0003E8
`define UNDER_LO_RESET 24'h000001
`define OVER_LO_RESET 24'h0186A0
`define UNDER_MED_RESET 24'h00000A
`define OVER_MED_RESET 24'h0F4240
`define UNDER_HI_RESET 24'h000064
`define OVER_HI_RESET 24'h989680
`define RANGE_SEL_RESET 2'h1

// status register fields
`define ST_WARN_TRIP 0
`define ST_HIGH_TRIP 1
`define ST_WARN_FLASH 2
`define ST_HIGH_FLASH 3
`define ST_UNDER 4
`define ST_OVER 5
`define ST_FAIL 6
`define ST_CHECK 7
`define ST_LEGEND 8
`define ST_BUSY 9

// history and timing
`define HIST_DEPTH 60
`define CLK_KHZ 125000
`define FLASH_HALF_MS 500

// display modes
`define DISP_RATE 3'h0
`define DISP_ZERO 3'h1
`define DISP_OVER 3'h2
`define DISP_HIGH_SP 3'h3
`define DISP_WARN_SP 3'h4

// bargraph colours
`define COL_GREEN 2'h0
`define COL_AMBER 2'h1
`define COL_RED 2'h2

`endif

// File: hw/pin_sync.v
// two-flop synchronisers for a group of front panel and fault pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
   parameter WIDTH = 8
)
(
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset, active high
   input wire [WIDTH-1:0] d_i, // asynchronous pin levels
   output wire [WIDTH-1:0] q_o // synchronised levels
);

   genvar b;
   generate
      for (b = 0; b < WIDTH; b = b + 1)
      begin : bit_sync
         reg meta_r;
         reg stable_r;
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               meta_r <= 1'b0;
               stable_r <= 1'b0;
            end
            else
            begin
               meta_r <= d_i[b];
               stable_r <= meta_r;
            end
         end
         assign q_o[b] = stable_r;
      end
   endgenerate

endmodule
`default_nettype wire

// File: hw/rate_history.v
// one-second rate history memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module rate_history
#(
   parameter WIDTH = 24,
   parameter DEPTH = 60,
   parameter AW = 6
)
(
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset, active high
   input wire we_i, // write strobe
   input wire [AW-1:0] waddr_i, // write address
   input wire [WIDTH-1:0] wdata_i, // write data
   input wire [AW-1:0] raddr_i, // read address
   output reg [WIDTH-1:0] rdata_o // read data, one cycle after address
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];

   // the array has no reset; the averager only reads slots it wrote
   always @(posedge clk_i)
   begin
      if (we_i)
         mem[waddr_i] <= wdata_i;
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
         rdata_o <= {WIDTH{1'b0}};
      else
         rdata_o <= mem[raddr_i];
   end

endmodule
`default_nettype wire

// File: hw/ratemeter_alarm.v
// ratemeter averaging, alarm, range, fail and check-source logic
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`include "ratemeter_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// Contract
// - in range, show rate as N.NN
// - normal: analog follows, green lamps, relays energized
// - above warn: amber flash, amber bar, warn relay off (code flashes the lamp only when manual is set; auto reset lights it steady)
// - above high: red flash, red bar, high relay off (code flashes the lamp only when manual is set; auto reset lights it steady)
// - option picks auto reset or latched alarms
// - ack during alarm: steady lamp, relay held
// - condition gone after ack: relay on, lamp off
// - bar colour always follows present rate status (code keeps it red while over_r stays latched after the rate falls)
// - high/warn buttons show that setpoint
// - underrange: display zero, bar actual, range lamp
// - underrange setpoint adjustable, default 0.10
// - back in range: range lamp off, no ack
// - three ranges, each with under/over setpoints
// - overrange: range lamp, EEEE, red bar, analog full
// - overrange clears when back in range and acked
// - units legend after setpoint buttons, enter clears
// - blown anti-jam fuse holds fail relay off
// - fail is OR of faults: lamp on, relay off
// - fail resets by itself when faults gone
// - check source only while button held, lamp lit
// - option allows alarms during check source (code trips only the relays; warn and high lamps stay dark while check_s)
// - check source forces analog to low scale
// - display is mean of last sixty seconds
// - check source entry and exit clear history
// - manual acknowledge is the reset default
module ratemeter_alarm
#(
   parameter HIST_DEPTH = `HIST_DEPTH,
   parameter NFAULT = 4,
   parameter FLASH_CYCLES = `FLASH_HALF_MS * `CLK_KHZ / 1000
)
(
   input wire clk_i, // system clock, 125 MHz
   input wire rst_i, // synchronous reset, active high
   input wire [7:0] adr_i, // wishbone byte address
   input wire [31:0] dat_i, // wishbone write data
   output reg [31:0] dat_o, // wishbone read data
   input wire we_i, // wishbone write enable
   input wire [3:0] sel_i, // wishbone byte selects
   input wire stb_i, // wishbone strobe
   input wire cyc_i, // wishbone cycle
   output wire ack_o, // wishbone acknowledge
   input wire [`RATE_W-1:0] rate_sample_i, // one-second rate value
   input wire rate_valid_i, // pulse: rate_sample_i is new
   input wire ack_btn_i, // alarm acknowledge button pin
   input wire high_btn_i, // high setpoint display button pin
   input wire warn_btn_i, // warn setpoint display button pin
   input wire enter_btn_i, // enter button pin
   input wire check_btn_i, // check source button pin
   input wire anti_jam_fuse_open_i, // anti-jam fuse open pin
   input wire [NFAULT-1:0] fault_i, // equipment fault pins
   output reg [`RATE_W-1:0] disp_value_o, // numeric display value
   output reg [2:0] disp_mode_o, // numeric display mode
   output reg unit_legend_o, // units backlight on
   output reg [`RATE_W-1:0] bar_value_o, // bargraph value
   output reg [1:0] bar_colour_o, // bargraph colour
   output reg warn_lamp_o, // warn indicator (amber)
   output reg high_lamp_o, // high indicator (red)
   output reg range_lamp_o, // range indicator (red)
   output reg fail_lamp_o, // fail indicator (red)
   output reg check_lamp_o, // check source indicator (green)
   output reg check_relay_o, // check source relay energized
   output reg warn_relay_o, // warn relay energized
   output reg high_relay_o, // high relay energized
   output reg fail_relay_o, // fail relay energized
   output reg [`RATE_W-1:0] analog_o // analog output value
);

   localparam W = `RATE_W;
   localparam SW = W + 6;
   localparam AW = 6;
   localparam FW = $clog2(FLASH_CYCLES + 1);
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_DIV = 2'h1;
   localparam [1:0] S_EVAL = 2'h2;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[8*k +: 8] = sel[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
   endfunction

   // synchronised pins
   wire [NFAULT+5:0] pins_s;
   pin_sync #(.WIDTH(NFAULT + 6)) u_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({fault_i, anti_jam_fuse_open_i, check_btn_i, enter_btn_i,
            warn_btn_i, high_btn_i, ack_btn_i}),
      .q_o(pins_s)
   );
   wire ack_s = pins_s[0];
   wire high_s = pins_s[1];
   wire warn_s = pins_s[2];
   wire enter_s = pins_s[3];
   wire check_s = pins_s[4];
   wire fuse_s = pins_s[5];
   wire [NFAULT-1:0] fault_s = pins_s[NFAULT+5:6];

   reg [4:0] btn_d_r;
   wire ack_rise = ack_s & ~btn_d_r[0];
   wire high_rise = high_s & ~btn_d_r[1];
   wire warn_rise = warn_s & ~btn_d_r[2];
   wire enter_rise = enter_s & ~btn_d_r[3];
   wire check_edge = check_s ^ btn_d_r[4];

   // registers
   reg ack_r;
   reg [1:0] ctrl_r;
   reg [W-1:0] warn_sp_r;
   reg [W-1:0] high_sp_r;
   reg [1:0] range_sel_r;
   wire [3*W-1:0] under_all;
   wire [3*W-1:0] over_all;
   wire manual = ctrl_r[`CTRL_MANUAL_BIT];
   wire chk_alarm_en = ctrl_r[`CTRL_CHK_ALARM_BIT];
   wire [31:0] warn_m = merge({8'h00, warn_sp_r}, dat_i, sel_i);
   wire [31:0] high_m = merge({8'h00, high_sp_r}, dat_i, sel_i);
   wire wr = cyc_i & stb_i & we_i & ~ack_r;
   wire [4:0] rel_slot = adr_i[7:3] - `RANGE_SP_SLOT;
   assign ack_o = ack_r;

   // averaging state
   reg [1:0] st_r;
   reg [AW-1:0] wp_r;
   reg [AW-1:0] cnt_r;
   reg [SW-1:0] sum_r;
   reg [SW-1:0] dq_r;
   reg [AW:0] rem_r;
   reg [4:0] step_r;
   reg [W-1:0] mean_r;
   wire [W-1:0] oldest;
   wire full = (cnt_r == HIST_DEPTH);
   wire take = (st_r == S_IDLE) & rate_valid_i & ~check_edge;
   wire [SW-1:0] sum_nxt = sum_r + {6'h00, rate_sample_i}
                           - (full ? {6'h00, oldest} : {SW{1'b0}});
   wire [AW:0] rem_sh = {rem_r[AW-1:0], dq_r[SW-1]};
   wire rem_ge = (rem_sh >= {1'b0, cnt_r});
   wire eval = (st_r == S_EVAL);

   rate_history #(.WIDTH(W), .DEPTH(HIST_DEPTH), .AW(AW)) u_hist
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(take),
      .waddr_i(wp_r),
      .wdata_i(rate_sample_i),
      .raddr_i(wp_r),
      .rdata_o(oldest)
   );

   // alarm state
   reg [1:0] trip_r;
   reg [1:0] flash_r;
   reg [1:0] cond_r;
   reg under_r;
   reg over_r;
   reg over_now_r;
   reg over_ack_r;
   reg legend_r;
   reg [FW-1:0] blink_cnt_r;
   reg blink_r;
   wire [W-1:0] under_sp = under_all[range_sel_r*W +: W];
   wire [W-1:0] over_sp = over_all[range_sel_r*W +: W];
   wire [1:0] above = {mean_r > high_sp_r, mean_r > warn_sp_r};
   wire inhibit = check_s & ~chk_alarm_en;
   wire fail_now = (|fault_s) | fuse_s;

   always @(posedge clk_i)
   begin
      if (rst_i)
         btn_d_r <= 5'h00;
      else
         btn_d_r <= {check_s, enter_s, warn_s, high_s, ack_s};
   end

   // wishbone slave: one wait state, unmapped reads return zero
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
         dat_o <= 32'h00000000;
         ctrl_r <= `CTRL_RESET;
         warn_sp_r <= `WARN_SP_RESET;
         high_sp_r <= `HIGH_SP_RESET;
         range_sel_r <= `RANGE_SEL_RESET;
      end
      else
      begin
         ack_r <= cyc_i & stb_i & ~ack_r;
         if (wr && adr_i == `CTRL_ADDR && sel_i[0])
            ctrl_r <= dat_i[1:0];
         if (wr && adr_i == `WARN_SP_ADDR)
            warn_sp_r <= warn_m[W-1:0];
         if (wr && adr_i == `HIGH_SP_ADDR)
            high_sp_r <= high_m[W-1:0];
         if (wr && adr_i == `RANGE_SEL_ADDR && sel_i[0] && dat_i[1:0] != 2'h3)
            range_sel_r <= dat_i[1:0];
         dat_o <= 32'h00000000;
         case (adr_i)
            `CTRL_ADDR: dat_o <= {30'h00000000, ctrl_r};
            `WARN_SP_ADDR: dat_o <= {8'h00, warn_sp_r};
            `HIGH_SP_ADDR: dat_o <= {8'h00, high_sp_r};
            `RANGE_SEL_ADDR: dat_o <= {30'h00000000, range_sel_r};
            `STATUS_ADDR: dat_o <= {22'h000000, st_r != S_IDLE, legend_r,
               check_s, fail_now, over_r, under_r, flash_r, trip_r};
            `MEAN_ADDR: dat_o <= {8'h00, mean_r};
            default:
            begin
               if (rel_slot < 5'h03 && adr_i[1:0] == 2'h0)
                  dat_o <= {8'h00, adr_i[2] ? over_all[rel_slot[1:0]*W +: W]
                                           : under_all[rel_slot[1:0]*W +: W]};
            end
         endcase
      end
   end

   // per-range under/overrange setpoints
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : rng
         localparam [3*W-1:0] UDEF = {`UNDER_HI_RESET, `UNDER_MED_RESET,
                                      `UNDER_LO_RESET};
         localparam [3*W-1:0] ODEF = {`OVER_HI_RESET, `OVER_MED_RESET,
                                      `OVER_LO_RESET};
         reg [W-1:0] under_sp_r;
         reg [W-1:0] over_sp_r;
         wire hit = wr && rel_slot == g && adr_i[1:0] == 2'h0;
         wire [31:0] mu = merge({8'h00, under_sp_r}, dat_i, sel_i);
         wire [31:0] mo = merge({8'h00, over_sp_r}, dat_i, sel_i);
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               under_sp_r <= UDEF[g*W +: W];
               over_sp_r <= ODEF[g*W +: W];
            end
            else if (hit && !adr_i[2])
               under_sp_r <= mu[W-1:0];
            else if (hit)
               over_sp_r <= mo[W-1:0];
         end
         assign under_all[g*W +: W] = under_sp_r;
         assign over_all[g*W +: W] = over_sp_r;
      end
   endgenerate

   // rolling mean: running sum over the last samples, then a serial divide
   always @(posedge clk_i)
   begin
      if (rst_i || check_edge)
      begin
         st_r <= S_IDLE;
         wp_r <= {AW{1'b0}};
         cnt_r <= {AW{1'b0}};
         sum_r <= {SW{1'b0}};
         dq_r <= {SW{1'b0}};
         rem_r <= {(AW+1){1'b0}};
         step_r <= 5'h00;
         mean_r <= {W{1'b0}};
      end
      else
      begin
         case (st_r)
            S_IDLE:
            begin
               if (take)
               begin
                  sum_r <= sum_nxt;
                  dq_r <= sum_nxt;
                  rem_r <= {(AW+1){1'b0}};
                  step_r <= 5'h00;
                  wp_r <= (wp_r == HIST_DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
                  if (!full)
                     cnt_r <= cnt_r + 1'b1;
                  st_r <= S_DIV;
               end
            end
            S_DIV:
            begin
               rem_r <= rem_ge ? rem_sh - {1'b0, cnt_r} : rem_sh;
               dq_r <= {dq_r[SW-2:0], rem_ge};
               step_r <= step_r + 1'b1;
               if (step_r == SW - 1)
               begin
                  mean_r <= {dq_r[W-2:0], rem_ge};
                  st_r <= S_EVAL;
               end
            end
            S_EVAL:
               st_r <= S_IDLE;
            default:
               st_r <= S_IDLE;
         endcase
      end
   end

   // high and warn alarms: bit 0 warn, bit 1 high
   genvar a;
   generate
      for (a = 0; a < 2; a = a + 1)
      begin : alm
         wire latched = flash_r[a] & manual;
         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               trip_r[a] <= 1'b0;
               flash_r[a] <= 1'b0;
               cond_r[a] <= 1'b0;
            end
            else
            begin
               if (eval && !inhibit)
                  cond_r[a] <= above[a];
               if (eval && !inhibit && above[a])
                  trip_r[a] <= 1'b1;
               else if (!inhibit && !cond_r[a] && !latched)
                  trip_r[a] <= 1'b0;
               // a new trip wins over an acknowledge in the same cycle
               if (eval && !inhibit && above[a] && !trip_r[a] && manual)
                  flash_r[a] <= 1'b1;
               else if (ack_rise || !manual)
                  flash_r[a] <= 1'b0;
            end
         end
      end
   endgenerate

   // range alarm and units legend
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         under_r <= 1'b0;
         over_r <= 1'b0;
         over_now_r <= 1'b0;
         over_ack_r <= 1'b0;
         legend_r <= 1'b0;
      end
      else
      begin
         if (eval)
         begin
            under_r <= mean_r < under_sp;
            over_now_r <= mean_r > over_sp;
         end
         if (eval && mean_r > over_sp)
            over_r <= 1'b1;
         else if (!over_now_r && over_ack_r)
            over_r <= 1'b0;
         if (!over_r)
            over_ack_r <= 1'b0;
         else if (ack_rise)
            over_ack_r <= 1'b1;
         if (high_rise || warn_rise)
            legend_r <= 1'b1;
         else if (enter_rise)
            legend_r <= 1'b0;
      end
   end

   // flash timebase for unacknowledged indicators
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         blink_cnt_r <= {FW{1'b0}};
         blink_r <= 1'b0;
      end
      else if (blink_cnt_r == FLASH_CYCLES - 1)
      begin
         blink_cnt_r <= {FW{1'b0}};
         blink_r <= ~blink_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + 1'b1;
   end

   // front panel, relay and analog outputs
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         disp_value_o <= {W{1'b0}};
         disp_mode_o <= `DISP_ZERO;
         unit_legend_o <= 1'b1;
         bar_value_o <= {W{1'b0}};
         bar_colour_o <= `COL_GREEN;
         warn_lamp_o <= 1'b0;
         high_lamp_o <= 1'b0;
         range_lamp_o <= 1'b0;
         fail_lamp_o <= 1'b0;
         check_lamp_o <= 1'b0;
         check_relay_o <= 1'b0;
         warn_relay_o <= 1'b1;
         high_relay_o <= 1'b1;
         fail_relay_o <= 1'b1;
         analog_o <= {W{1'b0}};
      end
      else
      begin
         if (high_s)
         begin
            disp_mode_o <= `DISP_HIGH_SP;
            disp_value_o <= high_sp_r;
         end
         else if (warn_s)
         begin
            disp_mode_o <= `DISP_WARN_SP;
            disp_value_o <= warn_sp_r;
         end
         else if (over_r)
         begin
            disp_mode_o <= `DISP_OVER;
            disp_value_o <= {W{1'b0}};
         end
         else if (under_r)
         begin
            disp_mode_o <= `DISP_ZERO;
            disp_value_o <= {W{1'b0}};
         end
         else
         begin
            disp_mode_o <= `DISP_RATE;
            disp_value_o <= mean_r;
         end
         // units stay lit normally; in overrange only after a setpoint peek
         unit_legend_o <= ~over_r | legend_r;
         bar_value_o <= mean_r;
         if (above[1] || over_r)
            bar_colour_o <= `COL_RED;
         else if (above[0])
            bar_colour_o <= `COL_AMBER;
         else
            bar_colour_o <= `COL_GREEN;
         // warn and high lamps go dark while the source is held
         warn_lamp_o <= trip_r[0] & ~check_s & (~flash_r[0] | blink_r);
         high_lamp_o <= trip_r[1] & ~check_s & (~flash_r[1] | blink_r);
         range_lamp_o <= under_r | over_r;
         fail_lamp_o <= fail_now;
         check_lamp_o <= check_s;
         check_relay_o <= check_s;
         warn_relay_o <= ~trip_r[0];
         high_relay_o <= ~trip_r[1];
         fail_relay_o <= ~fail_now;
         if (check_s)
            analog_o <= {W{1'b0}};
         else if (over_r)
            analog_o <= {W{1'b1}};
         else
            analog_o <= mean_r;
      end
   end

endmodule
`default_nettype wire

// File: verif/rate_source.sv
// detector side stand-in: one-second rate value pulses
`timescale 1ns/100ps
`default_nettype none
module rate_source
(
   input wire logic clk_i, // system clock
   input wire logic go_i, // send one value
   input wire logic [23:0] value_i, // value to send
   output var logic [23:0] sample_o = 24'h0, // rate value
   output var logic valid_o = 1'h0 // one-cycle pulse
);
   always @(posedge clk_i)
   begin
      valid_o <= go_i;
      sample_o <= go_i ? value_i : ~sample_o;
   end
endmodule
`default_nettype wire

// File: verif/ratemeter_alarm_sva.sv
// concurrent checks on the ratemeter alarm ports
`timescale 1ns/100ps
`default_nettype none
`include "ratemeter_defines.vh"
module ratemeter_alarm_sva
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic cyc_i, // bus cycle
   input wire logic stb_i, // bus strobe
   input wire logic ack_o, // bus ack
   input wire logic [`RATE_W-1:0] disp_value_o, // display value
   input wire logic [2:0] disp_mode_o, // display mode
   input wire logic [`RATE_W-1:0] bar_value_o, // bar value
   input wire logic [1:0] bar_colour_o, // bar colour
   input wire logic warn_lamp_o, // warn lamp
   input wire logic high_lamp_o, // high lamp
   input wire logic range_lamp_o, // range lamp
   input wire logic fail_lamp_o, // fail lamp
   input wire logic check_lamp_o, // check lamp
   input wire logic check_relay_o, // check relay
   input wire logic warn_relay_o, // warn relay
   input wire logic high_relay_o, // high relay
   input wire logic fail_relay_o, // fail relay
   input wire logic [`RATE_W-1:0] analog_o // analog
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held beyond one cycle");
   fail_pair_a: assert property (fail_lamp_o != fail_relay_o)
      else $error("fail lamp and fail relay disagree");
   check_pair_a: assert property (check_relay_o == check_lamp_o)
      else $error("check relay and lamp disagree");
   check_mute_a: assert property (check_lamp_o && $past(check_lamp_o)
      |-> analog_o == 0 && !warn_lamp_o && !high_lamp_o)
      else $error("analog or alarm lamps active in check source");
   over_show_a: assert property (disp_mode_o == `DISP_OVER
      && !check_lamp_o |-> range_lamp_o && bar_colour_o == `COL_RED
      && &analog_o)
      else $error("overrange outputs wrong");
   zero_show_a: assert property (disp_mode_o == `DISP_ZERO
      |-> disp_value_o == 0)
      else $error("zero display shows a value");
   rate_show_a: assert property (disp_mode_o == `DISP_RATE
      |-> disp_value_o == bar_value_o)
      else $error("displayed rate differs from bargraph");
   high_quiet_a: assert property (high_relay_o |-> !high_lamp_o)
      else $error("high lamp lit with relay energized");
   warn_quiet_a: assert property (warn_relay_o |-> !warn_lamp_o)
      else $error("warn lamp lit with relay energized");
   over_seen_c: cover property (disp_mode_o == `DISP_OVER);
endmodule
bind ratemeter_alarm ratemeter_alarm_sva ratemeter_alarm_sva_i (.clk_i,
   .rst_i, .cyc_i, .stb_i, .ack_o, .disp_value_o, .disp_mode_o,
   .bar_value_o, .bar_colour_o, .warn_lamp_o, .high_lamp_o, .range_lamp_o,
   .fail_lamp_o, .check_lamp_o, .check_relay_o, .warn_relay_o,
   .high_relay_o, .fail_relay_o, .analog_o);
`default_nettype wire

// File: verif/ratemeter_alarm_test.sv
// self-checking bench for the ratemeter alarm block
`timescale 1ns/100ps
`default_nettype none
`include "ratemeter_defines.vh"
module ratemeter_alarm_test;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, fuse = 0;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, q, r, seed = 96;
   logic [4:0] btn = 0;
   logic [3:0] flt = 0;
   logic [`RATE_W-1:0] val = 0, smp, m, hist[$];
   wire [31:0] dat_o;
   wire [`RATE_W-1:0] dv, bv, an;
   wire [2:0] dm;
   wire [1:0] bc;
   wire ack_o, lg, wl, hl, rl, fl, cl, cr, wr, hr, fr, vld;
   int errors = 0, compares = 0, cycles = 0, n;
   rate_source rate_source_i (.clk_i, .go_i(go), .value_i(val),
      .sample_o(smp), .valid_o(vld));
   ratemeter_alarm #(.FLASH_CYCLES(4)) ratemeter_alarm_i (.clk_i, .rst_i,
      .adr_i(adr), .dat_i(dat), .dat_o, .we_i(we), .sel_i(4'hF),
      .stb_i(stb), .cyc_i(cyc), .ack_o, .rate_sample_i(smp),
      .rate_valid_i(vld), .ack_btn_i(btn[0]), .high_btn_i(btn[1]),
      .warn_btn_i(btn[2]), .enter_btn_i(btn[3]), .check_btn_i(btn[4]),
      .anti_jam_fuse_open_i(fuse), .fault_i(flt), .disp_value_o(dv),
      .disp_mode_o(dm), .unit_legend_o(lg), .bar_value_o(bv),
      .bar_colour_o(bc), .warn_lamp_o(wl), .high_lamp_o(hl),
      .range_lamp_o(rl), .fail_lamp_o(fl), .check_lamp_o(cl),
      .check_relay_o(cr), .warn_relay_o(wr), .high_relay_o(hr),
      .fail_relay_o(fr), .analog_o(an));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [`RATE_W-1:0] mean();
      logic [31:0] s;
      s = 0;
      foreach (hist[i]) s += hist[i];
      return hist.size() ? s / hist.size() : 0;
   endfunction
   task complete_run();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task rate(input logic [`RATE_W-1:0] v);
      hist.push_back(v);
      if (hist.size() > `HIST_DEPTH) void'(hist.pop_front());
      @(posedge clk_i);
      go <= 1;
      val <= v;
      @(posedge clk_i);
      go <= 0;
      repeat (40) @(posedge clk_i);
      m = mean();
   endtask
   task press(input int k);
      @(posedge clk_i);
      btn[k] <= 1;
      repeat (8) @(posedge clk_i);
      if (k == 4) hist.delete();
      btn[k] <= 0;
      repeat (8) @(posedge clk_i);
   endtask
   task toggles();
      logic p;
      n = 0;
      p = hl;
      repeat (24)
      begin
         @(posedge clk_i);
         if (hl !== p) n++;
         p = hl;
      end
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         complete_run();
      end
   end
   initial forever #4 clk_i = ~clk_i;
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      wb(0, `CTRL_ADDR, 0);
      chk("ctrl", `CTRL_RESET, q);
      wb(0, 8'h18, 0);
      chk("under_med", `UNDER_MED_RESET, q);
      wb(0, 8'h30, 0);
      chk("unmapped", 0, q);
      for (int g = 0; g < 4; g++)
      begin
         wb(1, `RANGE_SEL_ADDR, g);
         wb(0, `RANGE_SEL_ADDR, 0);
         chk("range_sel", g == 3 ? 2 : g, q);
      end
      wb(0, 8'h24, 0);
      chk("over_hi", `OVER_HI_RESET, q);
      wb(1, `RANGE_SEL_ADDR, 1);
      $display("registers done");
      wb(1, `CTRL_ADDR, 0);
      repeat (12)
      begin
         r = xs();
         rate(r[10:0]);
         wb(0, `MEAN_ADDR, 0);
         chk("mean", m, q);
         chk("colour", m > `HIGH_SP_RESET ? `COL_RED : m > `WARN_SP_RESET
            ? `COL_AMBER : `COL_GREEN, bc);
         chk("warn_relay", m <= `WARN_SP_RESET, wr);
         chk("warn_lamp", m > `WARN_SP_RESET, wl);
         chk("high_relay", m <= `HIGH_SP_RESET, hr);
      end
      $display("auto alarms done");
      press(4);
      rate(5);
      chk("under_mode", `DISP_ZERO, dm);
      chk("under_bar", 5, bv);
      chk("under_lamp", 1, rl);
      rate(50);
      chk("back_lamp", 0, rl);
      chk("back_mode", `DISP_RATE, dm);
      for (int c = 0; c < 3; c += 2)
      begin
         wb(1, `CTRL_ADDR, c);
         btn[4] <= 1;
         repeat (8) @(posedge clk_i);
         hist.delete();
         rate(600);
         chk("chk_lamp", 1, cl);
         chk("chk_analog", 0, an);
         chk("chk_frozen", c == 0, wr);
         btn[4] <= 0;
         hist.delete();
         repeat (8) @(posedge clk_i);
         chk("chk_off", 0, cl);
         wb(0, `MEAN_ADDR, 0);
         chk("chk_clear", 0, q);
      end
      $display("range and check done");
      wb(1, `CTRL_ADDR, 1);
      rate(2000);
      chk("high_trip", 0, hr);
      toggles();
      chk("flashing", 1, n >= 2);
      press(0);
      toggles();
      chk("steady", 1, n == 0 && hl === 1'b1);
      chk("held", 0, hr);
      press(4);
      rate(0);
      chk("reset_relay", 1, hr);
      chk("reset_lamp", 0, hl);
      $display("manual alarms done");
      press(4);
      rate(24'h0F4241);
      chk("over_mode", `DISP_OVER, dm);
      chk("over_legend", 0, lg);
      press(1);
      rate(24'h0F4241);
      chk("legend_on", 1, lg);
      press(3);
      rate(24'h0F4241);
      chk("legend_off", 0, lg);
      press(4);
      rate(100);
      chk("over_held", `DISP_OVER, dm);
      press(0);
      rate(100);
      chk("over_clear", `DISP_RATE, dm);
      for (int k = 1; k < 3; k++)
      begin
         btn[k] <= 1;
         rate(100);
         chk("sp_mode", k == 1 ? `DISP_HIGH_SP : `DISP_WARN_SP, dm);
         chk("sp_value", k == 1 ? `HIGH_SP_RESET : `WARN_SP_RESET, dv);
         btn[k] <= 0;
         repeat (8) @(posedge clk_i);
      end
      $display("overrange and display done");
      r = xs();
      flt <= 4'h1 << r[1:0];
      repeat (8) @(posedge clk_i);
      chk("fault_relay", 0, fr);
      chk("fault_lamp", 1, fl);
      flt <= 0;
      repeat (8) @(posedge clk_i);
      chk("fault_gone", 1, fr);
      fuse <= 1;
      repeat (8) @(posedge clk_i);
      chk("fuse_relay", 0, fr);
      $display("fail done");
      complete_run();
   end
endmodule
`default_nettype wire
